// ==== hw/afsl_regs.svh ====
`ifndef AFSL_REGS_SVH
`define AFSL_REGS_SVH

// Register indices; byte address is index times four
`define AFSL_IDX_CFG 8'h00
`define AFSL_IDX_FCHR 8'h20
`define AFSL_IDX_FSPD 8'h22
`define AFSL_IDX_LTMP 8'h24
`define AFSL_IDX_RTMP 8'h25
`define AFSL_IDX_STAT 8'h28

// Reset values
`define AFSL_RST_CFG 8'h80
`define AFSL_RST_FCHR 8'h1D
`define AFSL_RST_FSPD 8'h05
`define AFSL_RST_LTMP 8'h44
`define AFSL_RST_RTMP 8'h64

// Field positions
`define AFSL_CFG_AUTO 7
`define AFSL_CFG_SEL_HI 6
`define AFSL_CFG_SEL_LO 5
`define AFSL_FCHR_SPIN_HI 2
`define AFSL_FCHR_SPIN_LO 0
`define AFSL_FSPD_MIN_HI 3
`define AFSL_FSPD_MIN_LO 0
`define AFSL_TMIN_HI 7
`define AFSL_TMIN_LO 3
`define AFSL_TRNG_HI 2
`define AFSL_TRNG_LO 0

// Loop constants
`define AFSL_SEL_REMOTE 2'h0
`define AFSL_SEL_FASTEST 2'h3
`define AFSL_TRNG_MAX 3'h4
`define AFSL_HYST_DEG 9'h005
`define AFSL_DUTY_FULL 4'hF
`define AFSL_DUTY_OFF 4'h0
`define AFSL_PWM_SLOTS 8'hF0

// Spin-up times in milliseconds
`define AFSL_SPIN_MS_0 14'h00C8
`define AFSL_SPIN_MS_1 14'h0190
`define AFSL_SPIN_MS_2 14'h0258
`define AFSL_SPIN_MS_3 14'h0320
`define AFSL_SPIN_MS_4 14'h03E8
`define AFSL_SPIN_MS_5 14'h07D0
`define AFSL_SPIN_MS_6 14'h0FA0
`define AFSL_SPIN_MS_7 14'h1F40

// Clock and PWM timing
`define AFSL_CLK_HZ 40000000
`define AFSL_MS_PER_S 1000
`define AFSL_PWM_CENTIHZ 3125
`define AFSL_CENTI 100

`endif

// ==== hw/afsl_pkg.sv ====
package afsl_pkg;
  // Spin-up sequencer states, Gray along off, spin, run
  typedef enum logic [1:0] {
    AFSL_OFF = 2'b00,
    AFSL_SPIN = 2'b01,
    AFSL_RUN = 2'b11
  } afsl_state_t;

  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } afsl_avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } afsl_avmm_rsp_t;

  typedef struct packed {
    logic [7:0] temp;
    logic valid;
  } afsl_meas_t;

  typedef struct packed {
    logic [4:0] tmin;
    logic [2:0] trange;
    logic [3:0] min_code;
  } afsl_loop_t;
endpackage

// ==== hw/afsl_chan_duty.sv ====
`include "afsl_regs.svh"

module afsl_chan_duty (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Async reset, active high
  input wire afsl_pkg::afsl_meas_t meas_i, // Temperature sample and strobe
  input wire afsl_pkg::afsl_loop_t loop_i, // Turn-on, range, minimum code
  output logic [3:0] duty_o, // Channel duty code
  output logic on_o // Channel wants the fan on
);
  import afsl_pkg::*;

  logic [3:0] duty_r, duty_nxt, headroom, duty_calc;
  logic on_r, on_nxt, above, below_hyst, full;
  logic [8:0] tmin_deg, temp9;
  logic [2:0] shift;
  logic [9:0] diff2, steps;

  // Temperatures in whole degrees, slope worked in half degrees
  assign temp9 = {1'b0, meas_i.temp};
  assign tmin_deg = {2'b00, loop_i.tmin, 2'b00}; // [R15]
  assign shift = (loop_i.trange > `AFSL_TRNG_MAX) ? `AFSL_TRNG_MAX : loop_i.trange; // [R15]
  assign above = temp9 > tmin_deg; // [R1]
  assign below_hyst = (temp9 + `AFSL_HYST_DEG) <= tmin_deg; // [R14]
  assign diff2 = above ? {temp9 - tmin_deg, 1'b0} : 10'h000;
  assign steps = diff2 >> shift; // [R12]
  assign headroom = `AFSL_DUTY_FULL - loop_i.min_code;
  assign full = steps >= {6'h00, headroom}; // [R9]
  assign duty_calc = full ? `AFSL_DUTY_FULL : loop_i.min_code + steps[3:0]; // [R10] [R12]

  // Hold the fan on until five degrees below turn-on
  assign on_nxt = !meas_i.valid ? on_r : above ? 1'b1 : below_hyst ? 1'b0 : on_r; // [R14]
  assign duty_nxt = !meas_i.valid ? duty_r : on_nxt ? duty_calc : `AFSL_DUTY_OFF; // [R18]

  // Recompute only on a fresh sample
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_r <= `AFSL_DUTY_OFF;
      on_r <= 1'b0;
    end else begin
      duty_r <= duty_nxt; // [R8]
      on_r <= on_nxt;
    end
  end

  assign duty_o = duty_r;
  assign on_o = on_r;

  property p_full_speed;
    @(posedge clk_i) disable iff (rst_i)
    (meas_i.valid && temp9 >= tmin_deg + ({5'h00, headroom} << shift) / 2 + 1 && headroom != 4'h0)
      |=> (duty_o == `AFSL_DUTY_FULL);
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("duty not full at full-speed temperature"); // [R9]

  property p_hyst_hold;
    @(posedge clk_i) disable iff (rst_i)
    (on_o && meas_i.valid && !below_hyst) |=> on_o;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("fan dropped inside hysteresis band"); // [R14]

  property p_turn_on_min;
    @(posedge clk_i) disable iff (rst_i)
    (meas_i.valid && !on_o && temp9 == tmin_deg + 9'h001 && shift > 3'h1) |=> (duty_o == $past(loop_i.min_code));
  endproperty
  a_turn_on_min: assert property (p_turn_on_min) else $error("turn-on duty is not the minimum code"); // [R1]
endmodule

// ==== hw/afsl_top.sv ====
// Contract
// [R1] Fan turns on at the minimum duty once selected temperature exceeds turn-on point.
// [R2] Turn-on first spins the fan for the programmed time, then calculated duty.
// [R3] Three-bit spin-up code selects 200 ms to 8 s, default 2 s.
// [R4] Configuration bit 7 set selects automatic control; clear gives software duty.
// [R5] Automatic mode is active after reset with no register write.
// [R6] Channel select 00 lets only the remote loop set the duty.
// [R7] Channel select 11 drives the larger of local and remote duties.
// [R8] Each channel has its own turn-on, range and independent duty.
// [R9] A channel at or above its full-speed temperature computes full duty.
// [R10] Minimum-duty nibble of fan speed register sets duty at turn-on.
// [R11] Duty code n gives n fifteenths of full scale, default code 5.
// [R12] Duty rises one code per tenth of the range above turn-on.
// [R13] Host programs loop parameters first and sets automatic mode last.
// [R14] Running fan stays on until five degrees below turn-on.
// [R15] Turn-on is five bits in 4 degree steps; range codes 5 to 80 degrees.
// [R16] Local loop settings at index 0x24, remote at 0x25.
// [R17] Spin-up drives full duty, then switches to calculated duty.
// [R18] Channel duty is recomputed on each completed measurement.
//
// The Avalon-MM interface to the registers is this design's own decision.
`include "afsl_regs.svh"

module afsl_top #(
  parameter int unsigned MS_CYCLES = `AFSL_CLK_HZ / `AFSL_MS_PER_S,
  parameter int unsigned PWM_SLOT_CYCLES =
    `AFSL_CLK_HZ / (`AFSL_PWM_CENTIHZ * `AFSL_PWM_SLOTS / `AFSL_CENTI)
) (
  input wire logic clk_i, // Core clock, 40 MHz
  input wire logic rst_i, // Async reset, active high
  input wire afsl_pkg::afsl_avmm_req_t avmm_i, // Avalon-MM request
  output afsl_pkg::afsl_avmm_rsp_t avmm_o, // Avalon-MM answer
  input wire afsl_pkg::afsl_meas_t local_meas_i, // Local sample and strobe
  input wire afsl_pkg::afsl_meas_t remote_meas_i, // Remote sample and strobe
  output logic pwm_o, // Fan drive
  output logic [3:0] duty_code_o // Duty code in force
);
  import afsl_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam int PSW = $clog2(PWM_SLOT_CYCLES + 1);

  // Register file
  logic [7:0] cfg_r, fchr_r, fspd_r, ltmp_r, rtmp_r;
  logic ack_r, busy, wr_en, rd_take;
  logic [7:0] idx, rd_mux;
  logic [31:0] rdata_r;

  // Loop and sequencer
  afsl_loop_t loop_cfg [2];
  afsl_meas_t meas [2];
  logic [3:0] chan_duty [2];
  logic chan_on [2];
  logic auto_mode, fan_on, tick;
  logic [1:0] sel;
  logic [2:0] spin_code;
  logic [3:0] sel_duty, tgt_code, min_code;
  logic [13:0] spin_ms, spin_left_r, spin_left_nxt;
  logic [MSW-1:0] pre_r, pre_nxt;
  afsl_state_t st_r, st_nxt;

  // PWM
  logic [PSW-1:0] spre_r, spre_nxt;
  logic [7:0] slot_r, slot_nxt;
  logic [3:0] applied_r, applied_nxt;
  logic pwm_r, pwm_nxt, slot_end, period_end;

  // Bus decode: one wait state, answer on the second cycle
  assign busy = avmm_i.read | avmm_i.write;
  assign idx = avmm_i.address[9:2];
  assign wr_en = avmm_i.write & ack_r & avmm_i.byteenable[0];
  assign rd_take = avmm_i.read & ~ack_r;
  assign avmm_o.waitrequest = busy & ~ack_r;
  assign avmm_o.readdata = rdata_r;

  // Read mux; unmapped words read as zero
  always_comb begin
    if (idx == `AFSL_IDX_CFG) begin
      rd_mux = cfg_r;
    end else if (idx == `AFSL_IDX_FCHR) begin
      rd_mux = fchr_r;
    end else if (idx == `AFSL_IDX_FSPD) begin
      rd_mux = fspd_r;
    end else if (idx == `AFSL_IDX_LTMP) begin
      rd_mux = ltmp_r;
    end else if (idx == `AFSL_IDX_RTMP) begin
      rd_mux = rtmp_r;
    end else if (idx == `AFSL_IDX_STAT) begin
      rd_mux = {st_r == AFSL_SPIN, st_r != AFSL_OFF, 2'b00, applied_r};
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Handshake and read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= busy & ~ack_r;
      if (rd_take) begin
        rdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Writable registers; automatic mode is the power-up state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= `AFSL_RST_CFG; // [R5]
      fchr_r <= `AFSL_RST_FCHR; // [R3]
      fspd_r <= `AFSL_RST_FSPD; // [R11]
      ltmp_r <= `AFSL_RST_LTMP;
      rtmp_r <= `AFSL_RST_RTMP;
    end else if (wr_en) begin
      if (idx == `AFSL_IDX_CFG) begin
        cfg_r <= avmm_i.writedata[7:0];
      end else if (idx == `AFSL_IDX_FCHR) begin
        fchr_r <= avmm_i.writedata[7:0];
      end else if (idx == `AFSL_IDX_FSPD) begin
        fspd_r <= avmm_i.writedata[7:0];
      end else if (idx == `AFSL_IDX_LTMP) begin
        ltmp_r <= avmm_i.writedata[7:0]; // [R16]
      end else if (idx == `AFSL_IDX_RTMP) begin
        rtmp_r <= avmm_i.writedata[7:0]; // [R16]
      end
    end
  end

  // Field extraction
  assign auto_mode = cfg_r[`AFSL_CFG_AUTO]; // [R4]
  assign sel = cfg_r[`AFSL_CFG_SEL_HI:`AFSL_CFG_SEL_LO];
  assign spin_code = fchr_r[`AFSL_FCHR_SPIN_HI:`AFSL_FCHR_SPIN_LO];
  assign min_code = fspd_r[`AFSL_FSPD_MIN_HI:`AFSL_FSPD_MIN_LO]; // [R10]
  assign meas[0] = local_meas_i;
  assign meas[1] = remote_meas_i;
  assign loop_cfg[0] = {ltmp_r[`AFSL_TMIN_HI:`AFSL_TMIN_LO], ltmp_r[`AFSL_TRNG_HI:`AFSL_TRNG_LO], min_code};
  assign loop_cfg[1] = {rtmp_r[`AFSL_TMIN_HI:`AFSL_TMIN_LO], rtmp_r[`AFSL_TRNG_HI:`AFSL_TRNG_LO], min_code};

  // One independent loop per channel: 0 local, 1 remote
  for (genvar c = 0; c < 2; c++) begin : g_chan
    afsl_chan_duty u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .meas_i(meas[c]),
      .loop_i(loop_cfg[c]),
      .duty_o(chan_duty[c]),
      .on_o(chan_on[c])
    ); // [R8]
  end

  // Channel selection; undefined codes behave as remote only
  assign fan_on = (sel == `AFSL_SEL_FASTEST) ? (chan_on[0] | chan_on[1]) : chan_on[1]; // [R6] [R7]
  assign sel_duty = (sel != `AFSL_SEL_FASTEST) ? chan_duty[1] : // [R6]
    (chan_duty[0] > chan_duty[1]) ? chan_duty[0] : chan_duty[1]; // [R7]

  // Spin-up time table in milliseconds
  always_comb begin
    case (spin_code)
      3'h0: spin_ms = `AFSL_SPIN_MS_0; // [R3]
      3'h1: spin_ms = `AFSL_SPIN_MS_1;
      3'h2: spin_ms = `AFSL_SPIN_MS_2;
      3'h3: spin_ms = `AFSL_SPIN_MS_3;
      3'h4: spin_ms = `AFSL_SPIN_MS_4;
      3'h5: spin_ms = `AFSL_SPIN_MS_5;
      3'h6: spin_ms = `AFSL_SPIN_MS_6;
      default: spin_ms = `AFSL_SPIN_MS_7;
    endcase
  end

  // Millisecond prescaler only runs while spinning up
  assign tick = (pre_r == MSW'(MS_CYCLES - 1));
  assign pre_nxt = (st_r != AFSL_SPIN || tick) ? '0 : pre_r + 1'b1;

  // Sequencer: leaving automatic mode or cooling down returns it to off at once
  always_comb begin
    st_nxt = st_r;
    spin_left_nxt = spin_left_r;
    case (st_r)
      AFSL_OFF: begin
        if (auto_mode && fan_on) begin
          st_nxt = AFSL_SPIN; // [R1] [R2]
          spin_left_nxt = spin_ms; // [R3]
        end
      end
      AFSL_SPIN: begin
        if (!auto_mode || !fan_on) begin
          st_nxt = AFSL_OFF;
        end else if (spin_left_r == 14'h0000) begin
          st_nxt = AFSL_RUN; // [R2]
        end else if (tick) begin
          spin_left_nxt = spin_left_r - 1'b1;
        end
      end
      AFSL_RUN: begin
        if (!auto_mode || !fan_on) begin
          st_nxt = AFSL_OFF; // [R14]
        end
      end
      default: st_nxt = AFSL_OFF;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= AFSL_OFF;
      spin_left_r <= 14'h0000;
      pre_r <= '0;
    end else begin
      st_r <= st_nxt;
      spin_left_r <= spin_left_nxt;
      pre_r <= pre_nxt;
    end
  end

  // Duty target: software code, full during spin-up, calculated while running, else off
  assign tgt_code = !auto_mode ? min_code : // [R4]
    (st_r == AFSL_SPIN) ? `AFSL_DUTY_FULL : // [R17]
    (st_r == AFSL_RUN) ? sel_duty : `AFSL_DUTY_OFF;

  // PWM: 240 slots, 16 per duty code; new code applied at period end to avoid runt pulses
  assign slot_end = (spre_r == PSW'(PWM_SLOT_CYCLES - 1));
  assign period_end = slot_end && (slot_r == `AFSL_PWM_SLOTS - 8'h01);
  assign spre_nxt = slot_end ? '0 : spre_r + 1'b1;
  assign slot_nxt = period_end ? 8'h00 : slot_end ? slot_r + 8'h01 : slot_r;
  assign applied_nxt = period_end ? tgt_code : applied_r;
  assign pwm_nxt = slot_nxt < {applied_nxt, 4'h0}; // [R11]

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      spre_r <= '0;
      slot_r <= 8'h00;
      applied_r <= `AFSL_DUTY_OFF;
      pwm_r <= 1'b0;
    end else begin
      spre_r <= spre_nxt;
      slot_r <= slot_nxt;
      applied_r <= applied_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign pwm_o = pwm_r;
  assign duty_code_o = applied_r;

  // Checks
  sequence s_turn_on;
    auto_mode && st_r == AFSL_OFF && fan_on;
  endsequence

  sequence s_spin_done;
    auto_mode && fan_on && st_r == AFSL_SPIN && spin_left_r == 14'h0000;
  endsequence

  property p_turn_on;
    @(posedge clk_i) disable iff (rst_i)
    s_turn_on |=> (st_r == AFSL_SPIN);
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("fan did not start spin-up"); // [R1]

  property p_spin_first;
    @(posedge clk_i) disable iff (rst_i)
    (st_r == AFSL_OFF) ##1 (st_r != AFSL_OFF) |-> (st_r == AFSL_SPIN);
  endproperty
  a_spin_first: assert property (p_spin_first) else $error("run entered without spin-up"); // [R2]

  property p_spin_done;
    @(posedge clk_i) disable iff (rst_i)
    s_spin_done |=> (st_r == AFSL_RUN);
  endproperty
  a_spin_done: assert property (p_spin_done) else $error("spin-up did not end on time"); // [R2]

  property p_spin_load;
    @(posedge clk_i) disable iff (rst_i)
    s_turn_on |=> (spin_left_r == ($past(spin_code) < 3'h4 ?
      14'({11'h000, $past(spin_code)} + 14'h0001) * `AFSL_SPIN_MS_0
      : `AFSL_SPIN_MS_4 << ($past(spin_code) - 3'h4)));
  endproperty
  a_spin_load: assert property (p_spin_load) else $error("spin-up time does not match code"); // [R3]

  property p_soft_mode;
    @(posedge clk_i) disable iff (rst_i)
    !auto_mode |-> (tgt_code == min_code) ##1 (st_r == AFSL_OFF);
  endproperty
  a_soft_mode: assert property (p_soft_mode) else $error("software mode not honoured"); // [R4]

  property p_spin_full;
    @(posedge clk_i) disable iff (rst_i)
    (auto_mode && st_r == AFSL_SPIN) |-> (tgt_code == `AFSL_DUTY_FULL);
  endproperty
  a_spin_full: assert property (p_spin_full) else $error("spin-up not at full duty"); // [R17]

  property p_remote_only;
    @(posedge clk_i) disable iff (rst_i)
    (auto_mode && sel == `AFSL_SEL_REMOTE && st_r == AFSL_RUN) |-> (tgt_code == chan_duty[1]);
  endproperty
  a_remote_only: assert property (p_remote_only) else $error("remote-only duty wrong"); // [R6]

  property p_fastest;
    @(posedge clk_i) disable iff (rst_i)
    (auto_mode && sel == `AFSL_SEL_FASTEST && st_r == AFSL_RUN)
      |-> (tgt_code >= chan_duty[0] && tgt_code >= chan_duty[1] &&
           (tgt_code == chan_duty[0] || tgt_code == chan_duty[1]));
  endproperty
  a_fastest: assert property (p_fastest) else $error("fastest duty not selected"); // [R7]

  property p_pwm_ends;
    @(posedge clk_i) disable iff (rst_i)
    (applied_r == `AFSL_DUTY_FULL) ##1 (applied_r == `AFSL_DUTY_FULL) |-> pwm_o;
  endproperty
  a_pwm_ends: assert property (p_pwm_ends) else $error("full duty output dropped low"); // [R11]

  property p_pwm_zero;
    @(posedge clk_i) disable iff (rst_i)
    (applied_r == `AFSL_DUTY_OFF) ##1 (applied_r == `AFSL_DUTY_OFF) |-> !pwm_o;
  endproperty
  a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty output went high"); // [R11]
endmodule

// ==== dv/afsl_fan_model.sv ====
module afsl_fan_model #(
  parameter int unsigned PERIOD = 480, // Clocks in one PWM period
  parameter int unsigned STEP = 32 // Clocks of high drive per duty code
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Async reset, active high
  input wire logic pwm_i, // Fan drive
  output logic [3:0] duty_seen_o // Duty code felt by the fan
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tick_r;
  logic [15:0] high_r;

  // Average over one whole period; any such window sees the true ratio
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_r <= 16'h0000;
      high_r <= 16'h0000;
      duty_seen_o <= 4'h0;
    end else if (tick_r == 16'(PERIOD - 1)) begin
      tick_r <= 16'h0000;
      high_r <= 16'h0000;
      duty_seen_o <= 4'((high_r + 16'(pwm_i)) / 16'(STEP));
    end else begin
      tick_r <= tick_r + 16'h0001;
      high_r <= high_r + 16'(pwm_i);
    end
  end
endmodule

// ==== dv/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import afsl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  afsl_avmm_req_t req = '0;
  afsl_avmm_rsp_t rsp;
  afsl_meas_t lm = '0;
  afsl_meas_t rm = '0;
  logic pwm;
  logic [3:0] duty;
  logic [3:0] seen;
  logic [31:0] rd;
  int cyc = 0;
  int failures = 0;
  int comparisons = 0;

  // 40 MHz core clock and a free cycle count
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  // Short ms and slot counts keep spin-up and PWM periods in reach
  afsl_top #(.MS_CYCLES(4), .PWM_SLOT_CYCLES(2)) DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .avmm_i(req),
    .avmm_o(rsp),
    .local_meas_i(lm),
    .remote_meas_i(rm),
    .pwm_o(pwm),
    .duty_code_o(duty)
  );
  afsl_fan_model #(.PERIOD(480), .STEP(32)) fan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pwm_i(pwm),
    .duty_seen_o(seen)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
    @(posedge clk_i);
    req.address <= {idx, 2'b00};
    req.read <= ~wr;
    req.write <= wr;
    req.writedata <= {24'h000000, wd};
    req.byteenable <= be;
    // No local limit: only the watchdog ends a stuck transfer
    do begin
      @(posedge clk_i);
    end while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hF);
    check(rd, {24'h000000, exp});
  endtask

  // Both channels strobed together for one cycle
  task automatic meas(input logic [7:0] lt, input logic [7:0] rt);
    @(posedge clk_i);
    lm <= {lt, 1'b1};
    rm <= {rt, 1'b1};
    @(posedge clk_i);
    lm.valid <= 1'b0;
    rm.valid <= 1'b0;
  endtask

  // Duty only moves at a PWM period end, so allow at least one period
  task automatic wait_duty(input logic [3:0] exp, input int lim);
    int n;
    n = 0;
    while (duty !== exp && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check(duty, exp);
  endtask

  task automatic t_reset();
    rdchk(8'h00, 8'h80);
    rdchk(8'h20, 8'h1D);
    rdchk(8'h22, 8'h05);
    rdchk(8'h24, 8'h44);
    rdchk(8'h25, 8'h64);
    rdchk(8'h01, 8'h00);
    bus(1'b1, 8'h22, 8'h0F, 4'hE);
    rdchk(8'h22, 8'h05);
    check(duty, 4'h0);
  endtask

  task automatic t_spin();
    int t0;
    wr(8'h20, 8'h19);
    meas(8'h00, 8'h30);
    repeat (600) @(posedge clk_i);
    check(duty, 4'h0);
    meas(8'h00, 8'h31);
    t0 = cyc;
    wait_duty(4'hF, 600);
    repeat (800) @(posedge clk_i);
    check(duty, 4'hF);
    wait_duty(4'h5, 1500);
    check(cyc - t0 >= 1600 && cyc - t0 <= 2120, 1);
  endtask

  task automatic t_hyst();
    meas(8'h00, 8'h2C);
    repeat (10) @(posedge clk_i);
    bus(1'b0, 8'h28, 8'h00, 4'hF);
    check(rd[6], 1'b1);
    meas(8'h00, 8'h2B);
    wait_duty(4'h0, 600);
  endtask

  // Entries: minimum code, range code, remote temperature, expected code
  task automatic t_slope();
    logic [31:0] tab [8];
    tab = '{32'h05_00_03_0B, 32'h05_01_04_09, 32'h05_02_0A_0A, 32'h08_03_14_0D,
            32'h08_03_1C_0F, 32'h0B_03_0F_0E, 32'h0B_03_10_0F, 32'h05_04_28_0A};
    for (int i = 0; i < 8; i++) begin
      wr(8'h22, tab[i][31:24]);
      wr(8'h25, {5'h00, tab[i][18:16]});
      meas(8'h00, tab[i][15:8]);
      wait_duty(tab[i][3:0], (i == 0) ? 2600 : 600);
    end
  endtask

  task automatic t_dual();
    wr(8'h22, 8'h05);
    wr(8'h24, 8'h2B);
    wr(8'h25, 8'h04);
    wr(8'h00, 8'hE0);
    meas(8'h3C, 8'h14);
    wait_duty(4'hF, 600);
    meas(8'h28, 8'h46);
    wait_duty(4'hD, 600);
    wr(8'h00, 8'h80);
    meas(8'h3C, 8'h14);
    wait_duty(4'h7, 600);
  endtask

  task automatic t_soft();
    wr(8'h22, 8'h0A);
    wr(8'h00, 8'h00);
    wait_duty(4'hA, 600);
    repeat (1000) @(posedge clk_i);
    check(seen, 4'hA);
  endtask

  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_spin();
    t_hyst();
    t_slope();
    t_dual();
    t_soft();
    conclude();
  end

  // Hang guard, well beyond the expected run of about 11000 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    conclude();
  end
endmodule
